// File: windowed_watchdog.sv
`timescale 1ns/1ps
module windowed_watchdog (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ext_reset,
   input wire logic count_clock,
   input wire wdt_pkg::apb_req_t apb_req,
   output wdt_pkg::apb_rsp_t apb_rsp,
   output logic reset_request,
   output logic warning_irq,
   output logic clock_lock
);

   wdt_pkg::wdt_state_t q;
   wdt_pkg::wdt_state_t d;
   logic tick;
   logic acc;
   logic done;
   logic wr;
   logic feed_wr;
   logic feed_ok;
   logic bad;
   logic guard;
   logic timeout;
   logic early;
   logic prot_err;
   logic [23:0] wdat;

   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      tick = 1'b0;
      feed_ok = 1'b0;
      bad = 1'b0;
      timeout = 1'b0;
      early = 1'b0;
      prot_err = 1'b0;
      acc = apb_req.psel & apb_req.penable;
      done = acc & q.rsp.pready;
      wr = done & apb_req.pwrite;
      feed_wr = wr & (apb_req.paddr == wdt_pkg::OFS_FEED);
      wdat = apb_req.pwdata[23:0];
      guard = q.watchdog_enable_bit & q.running;
      d.evt = 1'b0;

      // Count clock pin: three stages, a rise counts once stages two and three agree
      d.sync = {q.sync[1], q.sync[0], count_clock};
      if ((q.sync[2] == q.sync[1]) && (q.sync[2] != q.lvl)) begin
         d.lvl = q.sync[2];
         tick = q.sync[2];
      end

      // Prescaler and counter, free of any sleep gating
      if (tick && q.running) begin
         d.presc = q.presc + wdt_pkg::PRESC_ONE;
         if (q.presc == wdt_pkg::PRESC_LAST) begin
            if (q.count == wdt_pkg::COUNT_ZERO) begin
               timeout = 1'b1;
               d.count = q.reload_eff;
            end else begin
               d.count = q.count - wdt_pkg::COUNT_ONE;
               if (d.count == q.warning_compare) begin
                  d.warning_flag = 1'b1;
               end
            end
         end
      end
      if (tick) begin
         d.cap = q.count;
      end
      d.readback = q.cap;

      // Mode and reload crossing into the counting side
      if (tick && (q.pend != 2'h0)) begin
         d.pend = q.pend - wdt_pkg::SYNC_ONE;
         if (q.pend == wdt_pkg::SYNC_ONE) begin
            d.reload_eff = q.reload_constant;
            d.reset_en_eff = q.timeout_reset_enable;
         end
      end

      // Feed sequence
      if (done) begin
         if (q.armed) begin
            d.armed = 1'b0;
            if (feed_wr && (apb_req.pwdata[7:0] == wdt_pkg::FEED_SECOND)) begin
               feed_ok = 1'b1;
            end else begin
               bad = 1'b1;
            end
         end else if (feed_wr && (apb_req.pwdata[7:0] == wdt_pkg::FEED_FIRST)) begin
            d.armed = 1'b1;
         end
      end
      if (feed_ok) begin
         if (q.feed_protect && ((q.count >= q.warning_compare) || (q.count >= q.window_compare))) begin
            prot_err = 1'b1;
         end else if (q.running && (q.count > q.window_compare)) begin
            early = 1'b1;
         end else begin
            d.count = q.reload_eff;
            d.presc = 2'h0;
            d.running = q.watchdog_enable_bit;
         end
      end

      // Register writes; a bad access never writes
      if (wr && !bad) begin
         unique case (apb_req.paddr)
            wdt_pkg::OFS_MODE: begin
               d.watchdog_enable_bit = q.watchdog_enable_bit | apb_req.pwdata[wdt_pkg::BIT_ENABLE];
               d.timeout_reset_enable = q.timeout_reset_enable | apb_req.pwdata[wdt_pkg::BIT_RESET_EN];
               d.feed_protect = q.feed_protect | apb_req.pwdata[wdt_pkg::BIT_PROTECT];
               d.lock = q.lock | apb_req.pwdata[wdt_pkg::BIT_LOCK];
               if (!apb_req.pwdata[wdt_pkg::BIT_TIMEOUT]) begin
                  d.timeout_flag = 1'b0;
               end
               if (apb_req.pwdata[wdt_pkg::BIT_WARNING]) begin
                  d.warning_flag = 1'b0;
               end
               d.pend = wdt_pkg::SYNC_TICKS;
            end
            wdt_pkg::OFS_RELOAD: begin
               if (q.feed_protect) begin
                  prot_err = 1'b1;
               end else begin
                  d.reload_constant = (wdat < wdt_pkg::RELOAD_MIN) ? wdt_pkg::RELOAD_MIN : wdat;
                  d.pend = wdt_pkg::SYNC_TICKS;
               end
            end
            wdt_pkg::OFS_WARN: d.warning_compare = wdat;
            wdt_pkg::OFS_WINDOW: d.window_compare = wdat;
            default: ;
         endcase
      end

      // Events; an event's set wins over a clear in the same cycle, but a clear beats the warning compare set
      if (timeout || (guard && (bad || early || prot_err))) begin
         d.evt = 1'b1;
         d.timeout_flag = 1'b1;
         if (!q.reset_en_eff) begin
            d.warning_flag = 1'b1;
         end
      end
      if (q.warning_flag && timeout) begin
         d.warning_flag = 1'b1;
      end
      d.rst_req = q.rst_req | (q.evt & q.reset_en_eff);

      // Bus answer: one wait state, read data stands while pready is high
      d.rsp.pready = acc & ~q.rsp.pready;
      d.rsp.prdata = wdt_pkg::DATA_ZERO;
      d.rsp.pslverr = 1'b0;
      if (acc && !q.rsp.pready) begin
         unique case (apb_req.paddr)
            wdt_pkg::OFS_MODE: d.rsp.prdata = {26'h000_0000, q.lock, q.feed_protect, q.warning_flag,
                                               q.timeout_flag, q.timeout_reset_enable, q.watchdog_enable_bit};
            wdt_pkg::OFS_RELOAD: d.rsp.prdata = {8'h00, q.reload_constant};
            wdt_pkg::OFS_FEED: d.rsp.prdata = wdt_pkg::DATA_ZERO;
            wdt_pkg::OFS_READBACK: d.rsp.prdata = {8'h00, q.readback};
            wdt_pkg::OFS_WARN: d.rsp.prdata = {8'h00, q.warning_compare};
            wdt_pkg::OFS_WINDOW: d.rsp.prdata = {8'h00, q.window_compare};
            default: d.rsp.pslverr = 1'b1;
         endcase
      end

      // Synchronous reset; the time-out flag survives all but an external reset
      if (!rst_b) begin
         d = '0;
         d.count = wdt_pkg::RST_COUNT;
         d.reload_constant = wdt_pkg::RELOAD_MIN;
         d.reload_eff = wdt_pkg::RELOAD_MIN;
         d.warning_compare = wdt_pkg::RST_WARN;
         d.window_compare = wdt_pkg::RST_WINDOW;
         d.cap = wdt_pkg::RST_COUNT;
         d.readback = wdt_pkg::RST_COUNT;
         d.timeout_flag = q.timeout_flag & ~ext_reset;
      end
   end

   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   assign apb_rsp = q.rsp;
   assign reset_request = q.rst_req;
   assign warning_irq = q.warning_flag;
   assign clock_lock = q.lock;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   sequence last_step_s;
      tick && q.running && (q.presc == wdt_pkg::PRESC_LAST) && (q.count != wdt_pkg::COUNT_ZERO);
   endsequence

   sequence bad_access_s;
      bad && guard;
   endsequence

   presc_step_a: assert property (last_step_s ##0 !feed_ok |=> q.count == $past(q.count) - 24'h00_0001)
      else $error("counter did not step after four ticks");
   reload_floor_a: assert property (q.reload_constant >= wdt_pkg::RELOAD_MIN)
      else $error("reload constant below minimum");
   timeout_flag_a: assert property (timeout |=> q.timeout_flag ##1 (q.rst_req == $past(q.reset_en_eff, 2)))
      else $error("time-out did not flag or reset as configured");
   feed_reload_a: assert property (feed_ok && !prot_err && !early |=> q.count == $past(q.reload_eff))
      else $error("feed did not reload counter");
   early_feed_a: assert property (feed_ok && guard && !q.feed_protect && (q.count > q.window_compare)
                                  |=> q.timeout_flag)
      else $error("early feed not flagged");
   warn_set_a: assert property (last_step_s ##0 (q.count - 24'h00_0001 == q.warning_compare) |=> warning_irq)
      else $error("warning not raised at compare");
   bad_feed_a: assert property (bad_access_s ##0 q.reset_en_eff |=> q.timeout_flag ##1 reset_request)
      else $error("feed error not answered on second cycle");
   enable_sticky_a: assert property (q.watchdog_enable_bit |=> q.watchdog_enable_bit)
      else $error("enable cleared without reset");
   protect_sticky_a: assert property (q.feed_protect |=> q.feed_protect)
      else $error("protect cleared without reset");
   lock_hold_a: assert property (q.lock |=> clock_lock [*2])
      else $error("clock lock dropped");
   no_early_err_a: assert property (bad && !q.running && !timeout |=> !q.evt)
      else $error("error raised before first feed");

endmodule

// File: wdt_pkg.sv
package wdt_pkg;

   // ==========================================================
   // Register map (byte addresses on the APB)
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_RELOAD = 8'h04;
   localparam logic [7:0] OFS_FEED = 8'h08;
   localparam logic [7:0] OFS_READBACK = 8'h0c;
   localparam logic [7:0] OFS_WARN = 8'h14;
   localparam logic [7:0] OFS_WINDOW = 8'h18;

   // ==========================================================
   // Mode control field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_RESET_EN = 1;
   localparam int BIT_TIMEOUT = 2;
   localparam int BIT_WARNING = 3;
   localparam int BIT_PROTECT = 4;
   localparam int BIT_LOCK = 5;

   // ==========================================================
   // Values after reset, feed codes and counts
   localparam logic [23:0] RELOAD_MIN = 24'h00_00ff;
   localparam logic [23:0] RST_COUNT = 24'h00_00ff;
   localparam logic [23:0] RST_WARN = 24'h00_0000;
   localparam logic [23:0] RST_WINDOW = 24'hff_ffff;
   localparam logic [23:0] COUNT_ZERO = 24'h00_0000;
   localparam logic [23:0] COUNT_ONE = 24'h00_0001;
   localparam logic [7:0] FEED_FIRST = 8'haa;
   localparam logic [7:0] FEED_SECOND = 8'h55;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [1:0] PRESC_ONE = 2'h1;
   localparam logic [1:0] SYNC_TICKS = 2'h3;
   localparam logic [1:0] SYNC_ONE = 2'h1;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic [2:0] sync;
      logic lvl;
      logic [1:0] presc;
      logic [23:0] count;
      logic [23:0] reload_constant;
      logic [23:0] reload_eff;
      logic [23:0] warning_compare;
      logic [23:0] window_compare;
      logic [23:0] cap;
      logic [23:0] readback;
      logic watchdog_enable_bit;
      logic timeout_reset_enable;
      logic reset_en_eff;
      logic timeout_flag;
      logic warning_flag;
      logic feed_protect;
      logic lock;
      logic running;
      logic armed;
      logic [1:0] pend;
      logic evt;
      logic rst_req;
      apb_rsp_t rsp;
   } wdt_state_t;

endpackage

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic wr;
      logic [7:0] adr;
      logic [31:0] wd;
      logic [31:0] rd;
      logic er;
   } row_t;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic ext_reset = 1'b1;
   logic count_clock = 1'b0;
   logic [1:0] div_q = 2'h0;
   wdt_pkg::apb_req_t apb_req = '0;
   wdt_pkg::apb_rsp_t apb_rsp;
   logic reset_request;
   logic warning_irq;
   logic clock_lock;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   logic [31:0] rd;
   logic er;
   row_t rows [17] = '{
      '{1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_RELOAD, 32'h0000_0000, 32'h0000_00ff, 1'b0},
      '{1'b0, wdt_pkg::OFS_READBACK, 32'h0000_0000, 32'h0000_00ff, 1'b0},
      '{1'b0, wdt_pkg::OFS_WARN, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_WINDOW, 32'h0000_0000, 32'h00ff_ffff, 1'b0},
      '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b0, wdt_pkg::OFS_FEED, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b1, wdt_pkg::OFS_RELOAD, 32'h0000_0010, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_RELOAD, 32'h0000_0000, 32'h0000_00ff, 1'b0},
      '{1'b1, wdt_pkg::OFS_WARN, 32'h0000_00f8, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_WARN, 32'h0000_0000, 32'h0000_00f8, 1'b0},
      '{1'b1, wdt_pkg::OFS_MODE, 32'h0000_0020, 32'h0000_0000, 1'b0},
      '{1'b1, wdt_pkg::OFS_MODE, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000, 32'h0000_0020, 1'b0},
      '{1'b1, 8'h10, 32'h0000_1234, 32'h0000_0000, 1'b1},
      '{1'b1, wdt_pkg::OFS_RELOAD, 32'h0000_0100, 32'h0000_0000, 1'b0},
      '{1'b0, wdt_pkg::OFS_RELOAD, 32'h0000_0000, 32'h0000_0100, 1'b0}
   };

   windowed_watchdog DUT (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ext_reset(ext_reset),
      .count_clock(count_clock),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .reset_request(reset_request),
      .warning_irq(warning_irq),
      .clock_lock(clock_lock)
   );

   // ==========================================================
   // Clocks and timeout
   always #2.5 clk_sys = ~clk_sys;

   // Count clock period is eight system cycles
   always @(posedge clk_sys) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
         count_clock <= ~count_clock;
      end
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         results();
      end
   end

   // ==========================================================
   // Tasks
   task results;
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      int k;
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      k = 0;
      // Sampled at the rising edge, before that edge's updates land
      do begin
         @(posedge clk_sys);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors = num_errors + 1;
         results();
      end
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task rst(input logic ext);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      ext_reset <= ext;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      ext_reset <= 1'b0;
   endtask

   task feed;
      apb(1'b1, wdt_pkg::OFS_FEED, 32'h0000_00aa);
      apb(1'b1, wdt_pkg::OFS_FEED, 32'h0000_0055);
   endtask

   task wait_sig(input int lim, input logic which);
      n = 0;
      while ((which ? reset_request : warning_irq) !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst(1'b1);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].adr, rows[i].wd);
         chk({31'h0, er}, {31'h0, rows[i].er});
         if (rows[i].wr === 1'b0) begin
            chk(rd, rows[i].rd);
         end
      end
      chk({31'h0, clock_lock}, 32'h0000_0001);
      // Interrupt mode, errors before the first feed are ignored
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0001);
      repeat (40) @(posedge clk_sys);
      apb(1'b1, wdt_pkg::OFS_FEED, 32'h0000_00aa);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0021);
      feed();
      wait_sig(600, 1'b0);
      chk({31'h0, n >= 200 && n < 320}, 32'h0000_0001);
      apb(1'b0, wdt_pkg::OFS_READBACK, 32'h0000_0000);
      chk({31'h0, rd <= 32'h0000_00f9 && rd >= 32'h0000_00f0}, 32'h0000_0001);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0029);
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0008);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0021);
      chk({31'h0, warning_irq}, 32'h0000_0000);
      // Early feed against the window
      apb(1'b1, wdt_pkg::OFS_WINDOW, 32'h0000_0080);
      feed();
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_002d);
      chk({31'h0, reset_request}, 32'h0000_0000);
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0008);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0021);
      // Reset mode, broken feed sequence
      apb(1'b1, wdt_pkg::OFS_WINDOW, 32'h00ff_ffff);
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0003);
      repeat (40) @(posedge clk_sys);
      feed();
      apb(1'b1, wdt_pkg::OFS_FEED, 32'h0000_00aa);
      apb(1'b1, wdt_pkg::OFS_RELOAD, 32'h0000_0300);
      @(negedge clk_sys);
      chk({31'h0, reset_request}, 32'h0000_0000);
      @(negedge clk_sys);
      chk({31'h0, reset_request}, 32'h0000_0001);
      rst(1'b0);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      chk({31'h0, clock_lock, reset_request}, 32'h0000_0000);
      // Time-out to zero with reset enabled
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0003);
      repeat (40) @(posedge clk_sys);
      feed();
      wait_sig(10000, 1'b1);
      chk({31'h0, n >= 8000 && n < 8400}, 32'h0000_0001);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_000f);
      rst(1'b1);
      // Protect bit is sticky and refuses reload writes
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0010);
      apb(1'b1, wdt_pkg::OFS_MODE, 32'h0000_0000);
      apb(1'b0, wdt_pkg::OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
      apb(1'b1, wdt_pkg::OFS_RELOAD, 32'h0000_0200);
      apb(1'b0, wdt_pkg::OFS_RELOAD, 32'h0000_0000);
      chk(rd, 32'h0000_00ff);
      results();
   end
endmodule
